// [core/ils_pkg.sv]
// constants and types shared by the input lock and sync monitor
`default_nettype none
package ils_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int N_INPUTS = 2;
  localparam int SAMPLE_W = 24;
  localparam int BUF_W = 16;
  localparam int OFS_W = 8;
  localparam int MON_DELAY_SAMPLES = 3;
  localparam int PLAY_EXTRA_SAMPLES = 32;
  localparam int SAFETY_OFFSET_SAMPLES = 16;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int LOCK_TIMEOUT_US = 50;
  localparam int LOCK_TIMEOUT_CYC = (CLK_HZ / 1_000_000) * LOCK_TIMEOUT_US;
  localparam int LOCK_EDGES = 4;
  localparam int WIN_TICKS = 64;
  localparam int MASTER_DIV = 8;
  // status codes, gray along no lock -> lock -> sync
  typedef enum logic [1:0] {
    ILS_NO_LOCK = 2'h0,
    ILS_LOCK = 2'h1,
    ILS_SYNC = 2'h3
  } ils_state_e;
endpackage
`default_nettype wire

// [core/ils_if.sv]
// per-input link between the monitor top and one input checker
`default_nettype none
interface ils_if;
  logic work_tick;
  logic win_end;
  logic in_edge;
  ils_pkg::ils_state_e state;
  modport top (output work_tick, output win_end, output in_edge, input state);
  modport chan (input work_tick, input win_end, input in_edge, output state);
endinterface
`default_nettype wire

// [core/ils_chan.sv]
// lock and sync classification of one recovered input clock
`default_nettype none
module ils_chan #(
  parameter int TO_CYC = ils_pkg::LOCK_TIMEOUT_CYC,
  parameter int LOCK_EDGES = ils_pkg::LOCK_EDGES,
  parameter int WIN_TICKS = ils_pkg::WIN_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  ils_if.chan bus
);
  localparam int TW = $clog2(TO_CYC + 1);
  localparam int LW = $clog2(LOCK_EDGES + 1);
  localparam int CW = $clog2(2 * WIN_TICKS + 2);
  localparam logic [TW-1:0] TO_LAST = TW'(TO_CYC - 1);
  localparam logic [LW-1:0] LK_LAST = LW'(LOCK_EDGES - 1);
  localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] WIN_CNT = CW'(WIN_TICKS);
  localparam logic [CW-1:0] TK_LAST = CW'(WIN_TICKS - 1);

  if (TO_CYC < 2 || LOCK_EDGES < 1 || WIN_TICKS < 2) begin : g_bad
    $error("ils_chan: unsupported parameter values");
  end

  logic [TW-1:0] to_cnt;
  logic [LW-1:0] lk_cnt;
  logic [CW-1:0] ecnt;
  logic locked;
  logic no_sig;
  logic match;
  logic [CW-1:0] tick_seen;

  assign no_sig = (to_cnt == TO_LAST);
  assign match = ((ecnt + CW'(bus.in_edge)) == WIN_CNT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_cnt <= '0;
    end else if (bus.in_edge || no_sig) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= to_cnt + TW'(1);
    end
  end

  // lock holds through drift: only a missing carrier drops it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lk_cnt <= '0;
      locked <= 1'b0;
    end else if (no_sig) begin
      lk_cnt <= '0;
      locked <= 1'b0;
    end else if (bus.in_edge && !locked) begin
      lk_cnt <= lk_cnt + LW'(1);
      locked <= (lk_cnt == LK_LAST);
    end
  end

  // input edges counted per window of working-clock ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ecnt <= '0;
    end else if (bus.win_end) begin
      ecnt <= '0;
    end else if (bus.in_edge && ecnt != CNT_MAX) begin
      ecnt <= ecnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus.state <= ils_pkg::ILS_NO_LOCK;
    end else if (!locked || no_sig) begin
      bus.state <= ils_pkg::ILS_NO_LOCK;
    end else begin
      unique case (bus.state)
        ils_pkg::ILS_NO_LOCK: begin
          bus.state <= ils_pkg::ILS_LOCK;
        end
        ils_pkg::ILS_LOCK: begin
          if (bus.win_end && match) begin
            bus.state <= ils_pkg::ILS_SYNC;
          end
        end
        ils_pkg::ILS_SYNC: begin
          if (bus.win_end && !match) begin
            bus.state <= ils_pkg::ILS_LOCK;
          end
        end
        default: begin
          bus.state <= ils_pkg::ILS_NO_LOCK;
        end
      endcase
    end
  end

  property p_sync_needs_window;
    @(posedge clk) disable iff (!rstn)
    $rose(bus.state == ils_pkg::ILS_SYNC) |-> $past(bus.win_end);
  endproperty
  a_sync_needs_window: assert property (p_sync_needs_window)
    else $error("sync entered outside a window end");

  property p_mismatch_drops;
    @(posedge clk) disable iff (!rstn)
    (bus.win_end && bus.state == ils_pkg::ILS_SYNC && !match && locked && !no_sig)
      |=> bus.state == ils_pkg::ILS_LOCK;
  endproperty
  a_mismatch_drops: assert property (p_mismatch_drops)
    else $error("count mismatch did not drop sync to lock");

  property p_lock_kept;
    @(posedge clk) disable iff (!rstn)
    (locked && bus.in_edge) |=> ##1 bus.state != ils_pkg::ILS_NO_LOCK;
  endproperty
  a_lock_kept: assert property (p_lock_kept)
    else $error("lock lost while edges keep arriving");

  // working ticks seen since the last window end, for the window check below
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_seen <= '0;
    end else if (bus.win_end) begin
      tick_seen <= '0;
    end else if (bus.work_tick && tick_seen != CNT_MAX) begin
      tick_seen <= tick_seen + CW'(1);
    end
  end

  property p_window_length;
    @(posedge clk) disable iff (!rstn)
    bus.win_end |-> (bus.work_tick && tick_seen == TK_LAST);
  endproperty
  a_window_length: assert property (p_window_length)
    else $error("measurement window not closed on its last working tick");
endmodule
`default_nettype wire

// [core/ils_monitor.sv]
// input lock and sync monitor with indicators and fixed sample delays
// Overview of operation
// - An input that is locked but not synchronous to the working clock flashes its indicator.
// - An input that is locked and exactly synchronous holds its indicator steadily on.
// - Every input clock is compared against the working clock and only a mismatching one flashes.
// - Each input reports a readable status of exactly no lock, lock or sync.
// - In follow-input mode the working sample clock is taken from the selected input.
// - Monitored samples pass from receiver to transmitter with a delay of 3 samples.
// - The playback depth is the configured buffer size plus a fixed 32 samples.
// - A safety offset of 16 samples is reported as a constant, not applied; the host counts it twice.
`default_nettype none
module ils_monitor #(
  parameter int N_IN = ils_pkg::N_INPUTS,
  parameter int MASTER_DIV = ils_pkg::MASTER_DIV,
  parameter int WIN_TICKS = ils_pkg::WIN_TICKS,
  parameter int LOCK_EDGES = ils_pkg::LOCK_EDGES,
  parameter int LOCK_TO_CYC = ils_pkg::LOCK_TIMEOUT_CYC,
  parameter int FLASH_HALF_CYC = ils_pkg::FLASH_HALF_CYC,
  parameter int SEL_W = (N_IN > 1) ? $clog2(N_IN) : 1
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [N_IN-1:0] IN_CLK,
  input wire logic FOLLOW_INPUT_CLOCK_MODE,
  input wire logic [SEL_W-1:0] FOLLOW_SEL,
  input wire logic [ils_pkg::SAMPLE_W-1:0] MON_IN,
  input wire logic [ils_pkg::BUF_W-1:0] BUF_SIZE,
  output logic [N_IN-1:0] SYNC_INDICATOR,
  output logic [2*N_IN-1:0] INPUT_STATE,
  output logic WORK_TICK,
  output logic [ils_pkg::SAMPLE_W-1:0] MON_OUT,
  output logic [ils_pkg::BUF_W:0] PLAY_DEPTH,
  output logic [ils_pkg::OFS_W-1:0] SAFETY_OFFSET
);
  localparam int MW = $clog2(MASTER_DIV);
  localparam int WW = $clog2(WIN_TICKS);
  localparam int FW = $clog2(FLASH_HALF_CYC);
  localparam int ND = ils_pkg::MON_DELAY_SAMPLES;
  localparam logic [MW-1:0] M_LAST = MW'(MASTER_DIV - 1);
  localparam logic [WW-1:0] W_LAST = WW'(WIN_TICKS - 1);
  localparam logic [FW-1:0] F_LAST = FW'(FLASH_HALF_CYC - 1);
  localparam logic [ils_pkg::BUF_W:0] EXTRA = (ils_pkg::BUF_W + 1)'(ils_pkg::PLAY_EXTRA_SAMPLES);
  localparam logic [ils_pkg::OFS_W-1:0] SAFE = ils_pkg::OFS_W'(ils_pkg::SAFETY_OFFSET_SAMPLES);

  if (N_IN < 1 || MASTER_DIV < 2 || WIN_TICKS < 2 || LOCK_EDGES < 1 || LOCK_TO_CYC < 2
      || FLASH_HALF_CYC < 2 || (1 << SEL_W) < N_IN) begin : g_bad
    $error("ils_monitor: unsupported parameter values");
  end

  logic [N_IN-1:0] s1, s2, s3, in_edge;
  logic [MW-1:0] mcnt;
  logic [WW-1:0] wcnt;
  logic [FW-1:0] fcnt;
  logic master_tick, win_end, flash;
  logic [ils_pkg::SAMPLE_W-1:0] dly [ND];
  ils_pkg::ils_state_e st [N_IN];

  // two-flop synchronisers and rising-edge detection of each recovered clock
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= IN_CLK;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign in_edge = s2 & ~s3;

  // internal master sample clock
  assign master_tick = (mcnt == M_LAST);
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mcnt <= '0;
    end else begin
      mcnt <= master_tick ? '0 : mcnt + MW'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      WORK_TICK <= 1'b0;
    end else if (FOLLOW_INPUT_CLOCK_MODE) begin
      WORK_TICK <= in_edge[FOLLOW_SEL];
    end else begin
      WORK_TICK <= master_tick;
    end
  end

  // measurement window shared by all inputs
  assign win_end = WORK_TICK && (wcnt == W_LAST);
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      wcnt <= '0;
    end else if (WORK_TICK) begin
      wcnt <= (wcnt == W_LAST) ? '0 : wcnt + WW'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      fcnt <= '0;
      flash <= 1'b0;
    end else if (fcnt == F_LAST) begin
      fcnt <= '0;
      flash <= ~flash;
    end else begin
      fcnt <= fcnt + FW'(1);
    end
  end

  for (genvar i = 0; i < N_IN; i++) begin : g_in
    ils_if link ();
    assign link.work_tick = WORK_TICK;
    assign link.win_end = win_end;
    assign link.in_edge = in_edge[i];
    assign st[i] = link.state;

    ils_chan #(
      .TO_CYC(LOCK_TO_CYC),
      .LOCK_EDGES(LOCK_EDGES),
      .WIN_TICKS(WIN_TICKS)
    ) u_chan (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .bus(link.chan)
    );

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
        SYNC_INDICATOR[i] <= 1'b0;
        INPUT_STATE[2*i +: 2] <= ils_pkg::ILS_NO_LOCK;
      end else begin
        INPUT_STATE[2*i +: 2] <= st[i];
        unique case (st[i])
          ils_pkg::ILS_LOCK: SYNC_INDICATOR[i] <= flash;
          ils_pkg::ILS_SYNC: SYNC_INDICATOR[i] <= 1'b1;
          default: SYNC_INDICATOR[i] <= 1'b0;
        endcase
      end
    end

    property p_lock_flashes;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (st[i] == ils_pkg::ILS_LOCK) |=> SYNC_INDICATOR[i] == $past(flash);
    endproperty
    a_lock_flashes: assert property (p_lock_flashes)
      else $error("locked input indicator does not follow the flash");

    property p_sync_steady;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (st[i] == ils_pkg::ILS_SYNC) [*2] |=> SYNC_INDICATOR[i];
    endproperty
    a_sync_steady: assert property (p_sync_steady)
      else $error("synchronous input indicator not steadily on");

    property p_state_code;
      @(posedge CLK_SYS) disable iff (!RSTN)
      ##1 INPUT_STATE[2*i +: 2] != 2'h2 && INPUT_STATE[2*i +: 2] == $past(st[i]);
    endproperty
    a_state_code: assert property (p_state_code)
      else $error("reported input state wrong or illegal");
  end

  // monitor path delay line clocked by the working sample tick
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int k = 0; k < ND; k++) begin
        dly[k] <= '0;
      end
      MON_OUT <= '0;
    end else if (WORK_TICK) begin
      dly[0] <= MON_IN;
      for (int k = 1; k < ND; k++) begin
        dly[k] <= dly[k-1];
      end
      MON_OUT <= dly[ND-1];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PLAY_DEPTH <= EXTRA;
      SAFETY_OFFSET <= SAFE;
    end else begin
      PLAY_DEPTH <= {1'b0, BUF_SIZE} + EXTRA;
      SAFETY_OFFSET <= SAFE;
    end
  end

  property p_follow;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (FOLLOW_INPUT_CLOCK_MODE && in_edge[FOLLOW_SEL]) |=> WORK_TICK;
  endproperty
  a_follow: assert property (p_follow)
    else $error("working tick did not follow the selected input");

  property p_mon_moves_on_tick;
    @(posedge CLK_SYS) disable iff (!RSTN)
    !$stable(MON_OUT) |-> $past(WORK_TICK);
  endproperty
  a_mon_moves_on_tick: assert property (p_mon_moves_on_tick)
    else $error("monitor output changed without a sample tick");

  // skip the edge that releases reset, where the reset depth still stands
  property p_play_depth;
    @(posedge CLK_SYS) disable iff (!RSTN)
    RSTN |=> PLAY_DEPTH == {1'b0, $past(BUF_SIZE)} + 17'h00020;
  endproperty
  a_play_depth: assert property (p_play_depth)
    else $error("playback depth is not buffer size plus 32");

  property p_safety;
    @(posedge CLK_SYS) disable iff (!RSTN)
    SAFETY_OFFSET == 8'h10;
  endproperty
  a_safety: assert property (p_safety)
    else $error("safety offset is not 16");
endmodule
`default_nettype wire

// [verif/ils_src.sv]
// behavioural digital audio source that supplies a recovered sample clock
`default_nettype none
module ils_src (
  input wire logic en,
  input wire logic [15:0] half_ns,
  output logic clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock stands still low while the source is off; fixed phase keeps edges off the bench grid
  initial begin
    clk = 1'b0;
    forever begin
      wait (en);
      #7;
      while (en) begin
        #(half_ns) clk = 1'b1;
        #(half_ns) clk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb_ils_monitor.sv]
// self-checking bench for the input lock and sync monitor
`default_nettype none
module tb_ils_monitor;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS;
  logic RSTN;
  logic [1:0] in_clk;
  logic [1:0] src_en;
  logic [15:0] half_ns [2];
  logic follow;
  logic sel;
  logic [23:0] mon_in;
  logic [15:0] buf_size;
  logic [1:0] ind;
  logic [3:0] st;
  logic tick;
  logic [23:0] mon_out;
  logic [16:0] depth;
  logic [7:0] ofs;
  int errors;
  int num_checks;
  int seed = 32'hafe8;
  int g;
  logic [23:0] taps [$];

  for (genvar k = 0; k < 2; k++) begin : g_src
    ils_src ils_src_i (.en(src_en[k]), .half_ns(half_ns[k]), .clk(in_clk[k]));
  end

  ils_monitor #(.WIN_TICKS(8), .LOCK_TO_CYC(40), .FLASH_HALF_CYC(8)) ils_monitor_i (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .IN_CLK(in_clk), .FOLLOW_INPUT_CLOCK_MODE(follow),
    .FOLLOW_SEL(sel), .MON_IN(mon_in), .BUF_SIZE(buf_size), .SYNC_INDICATOR(ind),
    .INPUT_STATE(st), .WORK_TICK(tick), .MON_OUT(mon_out), .PLAY_DEPTH(depth),
    .SAFETY_OFFSET(ofs)
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  function automatic logic [31:0] exp_depth(input logic [15:0] b);
    return 32'(b) + 32'h20;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // 0: dark, 1: flashing, 2: steadily lit
  task automatic watch(input int idx, input int cls);
    int ones = 0;
    repeat (40) begin
      @(negedge CLK_SYS);
      ones += int'(ind[idx] === 1'b1);
    end
    chk(32'((ones == 0) ? 0 : (ones == 40) ? 2 : 1), 32'(cls));
  endtask

  task automatic gap(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(negedge CLK_SYS);
      n++;
    end
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (tick !== 1'b1 && n < 100);
  endtask

  // sample path: value taken at a tick must appear three ticks later
  always @(posedge CLK_SYS) begin
    if (RSTN) begin
      mon_in <= 24'($random(seed));
      if (tick === 1'b1) begin
        if (taps.size() >= 4) chk(32'(mon_out), 32'(taps[taps.size()-4]));
        taps.push_back(mon_in);
      end
    end
  end

  initial begin
    #100_000;
    errors++;
    report_and_stop();
  end

  initial begin
    RSTN = 1'b0;
    src_en = 2'b00;
    half_ns[0] = 16'h0050;
    half_ns[1] = 16'h0064;
    follow = 1'b0;
    sel = 1'b0;
    mon_in = 24'h000000;
    buf_size = 16'h0040;
    errors = 0;
    num_checks = 0;
    repeat (4) @(posedge CLK_SYS);
    chk(32'(st), 32'h0);
    chk(32'(ind), 32'h0);
    chk(32'(depth), 32'h20);
    chk(32'(ofs), 32'h10);
    RSTN <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK_SYS);
      buf_size <= (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      repeat (3) @(posedge CLK_SYS);
      chk(32'(depth), exp_depth(buf_size));
      chk(32'(ofs), 32'h10);
    end
    src_en <= 2'b11;
    follow <= 1'b1;
    sel <= 1'b1;
    repeat (400) @(posedge CLK_SYS);
    gap(g);
    chk(32'(g), 32'h0000000A);
    chk(32'(st), 32'hD);
    watch(0, 1);
    watch(1, 2);
    @(posedge CLK_SYS);
    sel <= 1'b0;
    repeat (400) @(posedge CLK_SYS);
    gap(g);
    chk(32'(g), 32'h00000008);
    chk(32'(st), 32'h7);
    watch(0, 2);
    watch(1, 1);
    @(posedge CLK_SYS);
    follow <= 1'b0;
    half_ns[1] <= 16'h0068;
    repeat (400) @(posedge CLK_SYS);
    chk(32'(st[3:2]), 32'h1);
    watch(1, 1);
    @(posedge CLK_SYS);
    src_en[0] <= 1'b0;
    repeat (100) @(posedge CLK_SYS);
    chk(32'(st[1:0]), 32'h0);
    watch(0, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
